// ==== bes_pkg.sv ====
/*
  Shared constants and types of the bus event sequencer: register map,
  action-word layout, comparator modes and the sampled bus-cycle record.
  Assumes a 32-bit classic Wishbone register bus, byte addressed.
*/
package bes_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_MASK = 8'h08;
  localparam logic [7:0] ADR_VECTOR = 8'h0C;
  localparam logic [7:0] ADR_STATE = 8'h10;
  // per-group block: bit 7 set, group in [6:5], field in [4:2]
  localparam int GRP_SEL_BIT = 7;
  localparam logic [2:0] GF_ADDR_LO = 3'h0;
  localparam logic [2:0] GF_ADDR_HI = 3'h1;
  localparam logic [2:0] GF_DATA = 3'h2;
  localparam logic [2:0] GF_STAT = 3'h3;
  localparam logic [2:0] GF_AUX = 3'h4;
  localparam logic [2:0] GF_ACTION = 3'h5;
  localparam logic [2:0] GF_LIMIT = 3'h6;

  // ==========================================================
  // control and status fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int EV_FSI = 0;
  localparam int EV_LIMIT = 1;
  localparam int EV_TRIG = 2;
  localparam int EV_GROUP = 3;
  localparam int EV_BREAK = 4;
  localparam int EV_W = 5;
  localparam logic [EV_W-1:0] EV_RESET = 5'h00;

  // ==========================================================
  // action word layout
  localparam int A_USE_AC = 0;
  localparam int A_USE_DC = 1;
  localparam int A_USE_ST = 2;
  localparam int A_USE_AUX = 3;
  localparam int A_USE_CL = 4;
  localparam int A_NEGATE = 5;
  localparam int A_TRIGGER = 8;
  localparam int A_FSI = 9;
  localparam int A_TRACE_Q = 10;
  localparam int A_TRACE_T = 11;
  localparam int A_COUNT_Q = 12;
  localparam int A_COUNT_T = 13;
  localparam int A_RELOAD = 14;
  localparam int A_GROUP_SW = 15;
  localparam int A_TGT_LO = 16;
  localparam int A_BREAK = 18;

  // ==========================================================
  // comparator widths and mode-dependent masks
  localparam int ADDR_CMP_W = 24;
  localparam int STAT_W = 15;
  localparam logic [15:0] AUX_MODE3_DC = 16'h00FF;

  typedef enum logic [1:0] {
    BES_MODE0 = 2'b00,
    BES_MODE1 = 2'b01,
    BES_MODE2 = 2'b10,
    BES_MODE3 = 2'b11
  } bes_mode_e;

  typedef struct packed {
    logic strobe;
    logic exception_return;
    logic [31:0] addr;
    logic [31:0] data;
    logic [14:0] status;
    logic [15:0] aux;
    logic [31:0] next_pc;
  } bes_cycle_s;

endpackage : bes_pkg

// ==== bes_bus_event_sequencer.sv ====
/*
  Bus event sequencer: watches sampled target bus cycles with address,
  data, status and auxiliary-pod comparators in four event groups, drives
  trigger, trace and break outputs and forces a vectored special interrupt.
  Assumes target pins are asynchronous to clk_i and that each bus cycle
  keeps its strobe high for at least three clocks.
*/
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module bes_bus_event_sequencer #(
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // target bus pins
  input wire logic tgt_strobe_i,
  input wire logic tgt_rte_i,
  input wire logic [31:0] tgt_addr_i,
  input wire logic [31:0] tgt_data_i,
  input wire logic [14:0] tgt_status_i,
  input wire logic [15:0] tgt_aux_i,
  input wire logic [31:0] tgt_next_pc_i,
  // outputs
  output logic trigger_o,
  output logic trace_capture_o,
  output logic break_req_o,
  output logic redirect_o,
  output logic [31:0] redirect_addr_o,
  output logic fsi_active_o,
  output logic irq_o
);

  // ==========================================================
  // pin synchronisers
  bes_pkg::bes_cycle_s pin_s, smp1_q, smp2_q;
  logic strobe3_q, rte3_q;
  assign pin_s = '{strobe: tgt_strobe_i, exception_return: tgt_rte_i, addr: tgt_addr_i,
                   data: tgt_data_i, status: tgt_status_i, aux: tgt_aux_i,
                   next_pc: tgt_next_pc_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smp1_q <= '0;
      smp2_q <= '0;
      strobe3_q <= 1'b0;
      rte3_q <= 1'b0;
    end else begin
      smp1_q <= pin_s;
      smp2_q <= smp1_q;
      strobe3_q <= smp2_q.strobe;
      rte3_q <= smp2_q.exception_return;
    end
  end

  logic cyc_start, rte_seen;
  assign cyc_start = smp2_q.strobe & ~strobe3_q;
  assign rte_seen = smp2_q.exception_return & ~rte3_q;

  // ==========================================================
  // register storage
  logic run_q;
  logic [1:0] mode_q;
  logic [bes_pkg::EV_W-1:0] stat_q, mask_q, ev_set;
  logic [31:0] vector_q;
  logic [23:0] addr_lo_q [4];
  logic [23:0] addr_hi_q [4];
  logic [31:0] dcmp_q [4];
  logic [31:0] scmp_q [4];
  logic [31:0] acmp_q [4];
  logic [31:0] act_q [4];
  logic [CNT_W-1:0] limit_q [4];
  logic [1:0] grp_q;
  logic [CNT_W-1:0] cnt_q;
  logic trace_on_q, count_on_q, fsi_busy_q;
  logic [31:0] ret_addr_q;

  logic wb_req, wr_req, rd_clr, run_start, stop_run;
  logic [1:0] wgrp;
  logic [2:0] wfld;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_req = wb_req & wb_we_i;
  assign rd_clr = wb_req & ~wb_we_i & (wb_adr_i == bes_pkg::ADR_STATUS);
  assign wgrp = wb_adr_i[6:5];
  assign wfld = wb_adr_i[4:2];

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  logic [31:0] ctrl_w;
  logic [31:0] mask_w;
  assign ctrl_w = merge({29'h0, mode_q, run_q}, wb_dat_i, wb_sel_i);
  assign mask_w = merge({27'h0, mask_q}, wb_dat_i, wb_sel_i);
  assign run_start = wr_req & (wb_adr_i == bes_pkg::ADR_CTRL)
                     & ctrl_w[bes_pkg::CTRL_RUN] & ~run_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
      mode_q <= 2'h0;
      mask_q <= bes_pkg::EV_RESET;
      vector_q <= 32'h0;
    end else begin
      if (stop_run) begin
        run_q <= 1'b0;
      end else if (wr_req && wb_adr_i == bes_pkg::ADR_CTRL) begin
        run_q <= ctrl_w[bes_pkg::CTRL_RUN];
      end
      if (wr_req && wb_adr_i == bes_pkg::ADR_CTRL) begin
        mode_q <= ctrl_w[bes_pkg::CTRL_MODE_LO +: 2];
      end
      if (wr_req && wb_adr_i == bes_pkg::ADR_MASK) begin
        mask_q <= mask_w[bes_pkg::EV_W-1:0];
      end
      if (wr_req && wb_adr_i == bes_pkg::ADR_VECTOR) begin
        vector_q <= merge(vector_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int g = 0; g < 4; g++) begin
        addr_lo_q[g] <= 24'h0;
        addr_hi_q[g] <= 24'h0;
        dcmp_q[g] <= 32'h0;
        scmp_q[g] <= 32'h0;
        acmp_q[g] <= 32'h0;
        act_q[g] <= 32'h0;
        limit_q[g] <= '0;
      end
    end else if (wr_req && wb_adr_i[bes_pkg::GRP_SEL_BIT]) begin
      case (wfld)
        bes_pkg::GF_ADDR_LO: addr_lo_q[wgrp] <=
          24'(merge({8'h0, addr_lo_q[wgrp]}, wb_dat_i, wb_sel_i));
        bes_pkg::GF_ADDR_HI: addr_hi_q[wgrp] <=
          24'(merge({8'h0, addr_hi_q[wgrp]}, wb_dat_i, wb_sel_i));
        bes_pkg::GF_DATA: dcmp_q[wgrp] <= merge(dcmp_q[wgrp], wb_dat_i, wb_sel_i);
        bes_pkg::GF_STAT: scmp_q[wgrp] <= merge(scmp_q[wgrp], wb_dat_i, wb_sel_i);
        bes_pkg::GF_AUX: acmp_q[wgrp] <= merge(acmp_q[wgrp], wb_dat_i, wb_sel_i);
        bes_pkg::GF_ACTION: act_q[wgrp] <= merge(act_q[wgrp], wb_dat_i, wb_sel_i);
        bes_pkg::GF_LIMIT: limit_q[wgrp] <= CNT_W'(merge(32'(limit_q[wgrp]),
                                                         wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // ==========================================================
  // comparators of the current group
  logic [31:0] act;
  logic [14:0] st_in;
  logic [15:0] aux_in, aux_dc;
  logic ac_hit, dc_hit, st_hit, aux_hit, cl_hit, fire;
  assign act = act_q[grp_q];
  assign cl_hit = (cnt_q == '0);

  always_comb begin
    st_in = smp2_q.status;
    aux_in = smp2_q.aux;
    aux_dc = acmp_q[grp_q][31:16];
    case (bes_pkg::bes_mode_e'(mode_q))
      bes_pkg::BES_MODE1: aux_in = smp2_q.data[15:0];
      bes_pkg::BES_MODE2: st_in[14:7] = smp2_q.addr[31:24];
      bes_pkg::BES_MODE3: begin
        aux_in[15:8] = smp2_q.addr[31:24];
        aux_dc = aux_dc | bes_pkg::AUX_MODE3_DC;
      end
      default: ;
    endcase
  end

  // address range only on the low 24 bits
  assign ac_hit = (smp2_q.addr[23:0] >= addr_lo_q[grp_q])
                  && (smp2_q.addr[23:0] <= addr_hi_q[grp_q]);
  // data comparator always sees the upper half: value [15:0], don't-care [31:16]
  assign dc_hit = (((smp2_q.data[31:16] ^ dcmp_q[grp_q][15:0])
                   & ~dcmp_q[grp_q][31:16]) == 16'h0);
  // exact masked matches only, no ranges
  assign st_hit = (((st_in ^ scmp_q[grp_q][14:0])
                   & ~scmp_q[grp_q][30:16]) == 15'h0);
  assign aux_hit = (((aux_in ^ acmp_q[grp_q][15:0]) & ~aux_dc) == 16'h0);

  assign fire = (&{~act[bes_pkg::A_USE_AC] | ac_hit,
                   ~act[bes_pkg::A_USE_DC] | dc_hit,
                   ~act[bes_pkg::A_USE_ST] | st_hit,
                   ~act[bes_pkg::A_USE_AUX] | aux_hit,
                   ~act[bes_pkg::A_USE_CL] | cl_hit}) ^ act[bes_pkg::A_NEGATE];

  logic eval, do_fsi, do_sw, do_brk;
  logic [1:0] tgt_grp;
  assign eval = run_q & cyc_start;
  assign do_fsi = eval & fire & act[bes_pkg::A_FSI];
  assign do_sw = eval & fire & act[bes_pkg::A_GROUP_SW];
  assign do_brk = eval & fire & act[bes_pkg::A_BREAK];
  assign tgt_grp = act[bes_pkg::A_TGT_LO +: 2];
  assign stop_run = do_brk;

  // ==========================================================
  // group, counter and toggle state
  logic count_now, trace_now;
  assign count_now = act[bes_pkg::A_COUNT_Q] ? fire
                   : act[bes_pkg::A_COUNT_T] ? count_on_q : 1'b0;
  assign trace_now = act[bes_pkg::A_TRACE_Q] ? fire
                   : act[bes_pkg::A_TRACE_T] ? (trace_on_q ^ fire) : 1'b1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      grp_q <= 2'h0;
      trace_on_q <= 1'b0;
      count_on_q <= 1'b0;
    end else if (run_start) begin
      grp_q <= 2'h0;
      trace_on_q <= 1'b0;
      count_on_q <= 1'b0;
    end else if (do_sw) begin
      grp_q <= tgt_grp;
      trace_on_q <= 1'b0;
      count_on_q <= 1'b0;
    end else if (eval && fire) begin
      if (act[bes_pkg::A_TRACE_T]) begin
        trace_on_q <= ~trace_on_q;
      end
      if (act[bes_pkg::A_COUNT_T]) begin
        count_on_q <= ~count_on_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (run_start) begin
      cnt_q <= limit_q[0];
    end else if (eval && fire && act[bes_pkg::A_RELOAD]) begin
      cnt_q <= do_sw ? limit_q[tgt_grp] : limit_q[grp_q];
    end else if (eval && count_now && !cl_hit) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  // ==========================================================
  // trigger, trace and forced interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_q) begin
      trigger_o <= 1'b0;
    end else if (cyc_start) begin
      trigger_o <= fire & act[bes_pkg::A_TRIGGER];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trace_capture_o <= 1'b0;
    end else begin
      trace_capture_o <= run_q & cyc_start & (trace_now | fsi_busy_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fsi_busy_q <= 1'b0;
      ret_addr_q <= 32'h0;
      redirect_o <= 1'b0;
      redirect_addr_o <= 32'h0;
    end else begin
      redirect_o <= 1'b0;
      if (do_fsi && !fsi_busy_q) begin
        fsi_busy_q <= 1'b1;
        ret_addr_q <= smp2_q.next_pc;
        redirect_o <= 1'b1;
        redirect_addr_o <= vector_q;
      end else if (fsi_busy_q && rte_seen) begin
        fsi_busy_q <= 1'b0;
        redirect_o <= 1'b1;
        redirect_addr_o <= ret_addr_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fsi_active_o <= 1'b0;
      break_req_o <= 1'b0;
    end else begin
      fsi_active_o <= fsi_busy_q | (do_fsi & ~fsi_busy_q);
      break_req_o <= do_brk;
    end
  end

  // ==========================================================
  // sticky events, read clears, set wins
  assign ev_set = {do_brk, do_sw, eval & fire & act[bes_pkg::A_TRIGGER],
                   run_q & cl_hit, do_fsi};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= bes_pkg::EV_RESET;
      irq_o <= 1'b0;
    end else begin
      stat_q <= (rd_clr ? bes_pkg::EV_RESET : stat_q) | ev_set;
      irq_o <= |(((rd_clr ? bes_pkg::EV_RESET : stat_q) | ev_set) & mask_q);
    end
  end

  // ==========================================================
  // wishbone read path
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0;
    if (wb_adr_i[bes_pkg::GRP_SEL_BIT]) begin
      case (wfld)
        bes_pkg::GF_ADDR_LO: rd_d = {8'h0, addr_lo_q[wgrp]};
        bes_pkg::GF_ADDR_HI: rd_d = {8'h0, addr_hi_q[wgrp]};
        bes_pkg::GF_DATA: rd_d = dcmp_q[wgrp];
        bes_pkg::GF_STAT: rd_d = scmp_q[wgrp];
        bes_pkg::GF_AUX: rd_d = acmp_q[wgrp];
        bes_pkg::GF_ACTION: rd_d = act_q[wgrp];
        bes_pkg::GF_LIMIT: rd_d = 32'(limit_q[wgrp]);
        default: rd_d = 32'h0;
      endcase
    end else if (wb_adr_i == bes_pkg::ADR_CTRL) begin
      rd_d = {29'h0, mode_q, run_q};
    end else if (wb_adr_i == bes_pkg::ADR_STATUS) begin
      rd_d = {27'h0, stat_q};
    end else if (wb_adr_i == bes_pkg::ADR_MASK) begin
      rd_d = {27'h0, mask_q};
    end else if (wb_adr_i == bes_pkg::ADR_VECTOR) begin
      rd_d = vector_q;
    end else if (wb_adr_i == bes_pkg::ADR_STATE) begin
      rd_d = {26'h0, fsi_busy_q, cl_hit, count_on_q, trace_on_q, grp_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_d : 32'h0;
    end
  end

endmodule : bes_bus_event_sequencer
`default_nettype wire

// ==== bes_checker.sv ====
/*
  Checker for the bus event sequencer, bound to its top module.
  Assumes strobe of a target cycle stays high at least three clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module bes_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic tgt_strobe_i,
  input wire logic trigger_o,
  input wire logic trace_capture_o,
  input wire logic break_req_o,
  input wire logic redirect_o,
  input wire logic [31:0] redirect_addr_o,
  input wire logic fsi_active_o
);
  // ==========================================
  // properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_trig_start;
    $rose(trigger_o);
  endsequence
  a_ack_follows_req: assert property (s_wb_req |=> wb_ack_o) else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat idle");
  a_trace_has_cycle: assert property (trace_capture_o |-> $past(tgt_strobe_i, 2))
    else $error("trace without cycle");
  a_trace_single: assert property (trace_capture_o |=> !trace_capture_o)
    else $error("trace pulse long");
  a_trig_has_cycle: assert property (s_trig_start |-> $past(tgt_strobe_i, 2))
    else $error("trigger without cycle");
  a_trig_whole_cycle: assert property (s_trig_start |=> trigger_o [*3])
    else $error("trigger dropped");
  a_break_has_cycle: assert property (break_req_o |-> $past(tgt_strobe_i, 2))
    else $error("break without cycle");
  a_redir_single: assert property (redirect_o |=> !redirect_o)
    else $error("redirect long");
  a_redir_addr_holds: assert property (!redirect_o |-> $stable(redirect_addr_o))
    else $error("vector moved");
  a_fsi_with_redir: assert property ($rose(fsi_active_o) |-> redirect_o || $past(redirect_o))
    else $error("fsi without redirect");
endmodule : bes_checker
bind bes_bus_event_sequencer bes_checker chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_dat_o, .tgt_strobe_i, .trigger_o, .trace_capture_o, .break_req_o,
  .redirect_o, .redirect_addr_o, .fsi_active_o);
`default_nettype wire

// ==== bes_target_model.sv ====
/*
  Target bus model: runs monitored bus cycles and exception returns.
  Assumes the sequencer samples these pins on rising clk_i edges.
*/
`timescale 1ns/1ns
`default_nettype none
module bes_target_model (
  input wire logic clk_i,
  output var bes_pkg::bes_cycle_s bus_o
);
  initial bus_o = '0;
  task automatic run(input logic [31:0] ad, dd, input logic [14:0] ss, input logic [15:0] xx);
    @(posedge clk_i);
    bus_o <= '{1'h1, 1'h0, ad, dd, ss, xx, ad + 32'h4};
    repeat (5) @(posedge clk_i);
    // released lines show inverted values, next_pc the inverted address, exception_return stays low
    bus_o <= '{1'h0, 1'h0, ~ad, ~dd, ~ss, ~xx, ~ad};
    repeat (4) @(posedge clk_i);
  endtask : run
  task automatic exception_return();
    @(posedge clk_i);
    bus_o.exception_return <= 1'h1;
    repeat (4) @(posedge clk_i);
    bus_o.exception_return <= 1'h0;
    repeat (4) @(posedge clk_i);
  endtask : exception_return
endmodule : bes_target_model
`default_nettype wire

// ==== tb_bus_event_sequencer.sv ====
/*
  Self-checking bench of the bus event sequencer.
  Assumes the checker file and the target bus model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_bus_event_sequencer;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, redirect_addr_o;
  logic wb_ack_o, trigger_o, trace_capture_o, break_req_o, redirect_o, fsi_active_o, irq_o;
  bes_pkg::bes_cycle_s bus;
  int n_errors = 0, tests_run = 0, n_cyc = 0;
  logic [31:0] rq[$], aq[$];
  logic [2:0] tq[$];
  logic [2:0] seen = 3'h0;
  logic sd = 1'h0;
  logic [31:0] a, d, v, ca, cd, na, nd;
  logic [31:0] acts [4] = '{32'h103, 32'h10A, 32'h105, 32'h109};
  logic [15:0] x, nx;
  logic [14:0] s;

  initial begin
    forever #20 clk_i = ~clk_i;
  end
  bes_target_model model (.clk_i, .bus_o(bus));
  bes_bus_event_sequencer #(.CNT_W(16)) DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .tgt_strobe_i(bus.strobe),
    .tgt_rte_i(bus.exception_return), .tgt_addr_i(bus.addr), .tgt_data_i(bus.data),
    .tgt_status_i(bus.status), .tgt_aux_i(bus.aux), .tgt_next_pc_i(bus.next_pc), .trigger_o,
    .trace_capture_o, .break_req_o, .redirect_o, .redirect_addr_o, .fsi_active_o, .irq_o);

  // ==========================================
  // tasks
  task automatic final_report();
    $display("mismatches %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'h1) begin
      n_errors++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] dd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_dat_i <= dd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 40);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (n >= 40) begin
      chk(1'h0, "bus timeout");
      final_report();
    end
  endtask : wb
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    rq.push_back(e);
    wb(1'h0, ad, 32'h0);
  endtask : rd
  task automatic gw(input logic [1:0] g, input logic [2:0] f, input logic [31:0] val);
    wb(1'h1, {1'h1, g, f, 2'h0}, val);
  endtask : gw
  task automatic tc(input logic [31:0] ad, dd, input logic [15:0] xx, input logic [2:0] e);
    tq.push_back(e);
    model.run(ad, dd, s, xx);
  endtask : tc

  // ==========================================
  // watchers: expected {trigger, trace, break} per target cycle
  always @(posedge clk_i) begin
    n_cyc++;
    if (n_cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'h1 && !wb_we_i) chk(rq.size() > 0 && wb_dat_o === rq.pop_front(), "read");
    if (redirect_o === 1'h1) chk(aq.size() > 0 && redirect_addr_o === aq.pop_front(), "vector");
    if (bus.strobe) seen = seen | {1'h0, trace_capture_o, break_req_o};
    if (sd && !bus.strobe) begin
      chk(tq.size() > 0 && {trigger_o, seen[1:0]} === tq.pop_front(), "cycle outcome");
      seen = 3'h0;
    end
    sd = bus.strobe;
  end

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h969e));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    a = $urandom;
    d = $urandom;
    v = $urandom;
    s = $urandom;
    rd(bes_pkg::ADR_CTRL, 32'h0);
    rd(bes_pkg::ADR_VECTOR, 32'h0);
    wb(1'h1, 8'h40, v);
    rd(8'h40, 32'h0);
    gw(2'h0, bes_pkg::GF_ADDR_LO, {8'h00, a[23:0]});
    gw(2'h0, bes_pkg::GF_ADDR_HI, {8'h00, a[23:0]});
    gw(2'h0, bes_pkg::GF_DATA, {16'h0000, d[31:16]});
    gw(2'h0, bes_pkg::GF_STAT, {1'h0, 15'h007F, 1'h0, a[31:24], 7'h00});
    gw(2'h0, bes_pkg::GF_LIMIT, 32'h5);
    for (int m = 0; m < 4; m++) begin
      ca = a;
      cd = d;
      x = $urandom;
      nx = x;
      na = a ^ 32'h8000_0000;
      nd = d;
      case (m)
        0: begin
          ca = {~a[31:24], a[23:0]};
          cd = {d[31:16], ~d[15:0]};
          na = ca;
          nd = cd ^ 32'h8000_0000;
        end
        1: begin
          x = d[15:0];
          nx = x ^ 16'h1;
          na = a;
          nd = d ^ 32'h1;
        end
        2: na = a ^ 32'h0100_0000;
        default: ;
      endcase
      wb(1'h1, bes_pkg::ADR_CTRL, 32'h0);
      gw(2'h0, bes_pkg::GF_ACTION, acts[m]);
      gw(2'h0, bes_pkg::GF_AUX, m == 3 ? {16'h00FF, a[31:24], 8'h00} : {16'h0000, d[15:0]});
      wb(1'h1, bes_pkg::ADR_CTRL, {29'h0, m[1:0], 1'h1});
      tc(ca, cd, x, 3'h6);
      tc(na, nd, nx, 3'h2);
    end
    rd(bes_pkg::ADR_STATUS, 32'h4);
    rd(bes_pkg::ADR_STATUS, 32'h0);
    wb(1'h1, bes_pkg::ADR_CTRL, 32'h0);
    gw(2'h0, bes_pkg::GF_ACTION, 32'h201);
    wb(1'h1, bes_pkg::ADR_VECTOR, v);
    rd(bes_pkg::ADR_VECTOR, v);
    wb(1'h1, bes_pkg::ADR_MASK, 32'h0);
    wb(1'h1, bes_pkg::ADR_CTRL, 32'h1);
    aq.push_back(v);
    tc(a, d, x, 3'h2);
    chk(fsi_active_o === 1'h1, "fsi level");
    chk(irq_o === 1'h0, "masked irq");
    wb(1'h1, bes_pkg::ADR_MASK, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq_o === 1'h1, "irq");
    aq.push_back(a + 32'h4);
    model.exception_return();
    chk(fsi_active_o === 1'h0, "fsi end");
    rd(bes_pkg::ADR_STATUS, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq_o === 1'h0, "irq clear");
    wb(1'h1, bes_pkg::ADR_CTRL, 32'h0);
    gw(2'h0, bes_pkg::GF_ADDR_LO, 32'h100);
    gw(2'h0, bes_pkg::GF_ADDR_HI, 32'h100);
    gw(2'h0, bes_pkg::GF_ACTION, 32'h18101);
    gw(2'h1, bes_pkg::GF_ADDR_LO, 32'h200);
    gw(2'h1, bes_pkg::GF_ADDR_HI, 32'h200);
    gw(2'h1, bes_pkg::GF_ACTION, 32'h801);
    wb(1'h1, bes_pkg::ADR_CTRL, 32'h1);
    tc(32'h100, d, x, 3'h6);
    tc(32'h300, d, x, 3'h0);
    tc(32'h200, d, x, 3'h2);
    tc(32'h300, d, x, 3'h2);
    rd(bes_pkg::ADR_STATE, 32'h5);
    wb(1'h1, bes_pkg::ADR_CTRL, 32'h0);
    wb(1'h1, bes_pkg::ADR_CTRL, 32'h1);
    tc(32'h100, d, x, 3'h6);
    wb(1'h1, bes_pkg::ADR_CTRL, 32'h0);
    gw(2'h0, bes_pkg::GF_ACTION, 32'h1001);
    gw(2'h0, bes_pkg::GF_LIMIT, 32'h2);
    wb(1'h1, bes_pkg::ADR_CTRL, 32'h1);
    tc(32'h100, d, x, 3'h2);
    tc(32'h300, d, x, 3'h2);
    rd(bes_pkg::ADR_STATE, 32'h0);
    tc(32'h100, d, x, 3'h2);
    rd(bes_pkg::ADR_STATE, 32'h10);
    // count toggle: first toggling cycle is not counted
    wb(1'h1, bes_pkg::ADR_CTRL, 32'h0);
    gw(2'h0, bes_pkg::GF_ACTION, 32'h2001);
    wb(1'h1, bes_pkg::ADR_CTRL, 32'h1);
    tc(32'h100, d, x, 3'h2);
    tc(32'h300, d, x, 3'h2);
    rd(bes_pkg::ADR_STATE, 32'h8);
    tc(32'h300, d, x, 3'h2);
    rd(bes_pkg::ADR_STATE, 32'h18);
    // break pulse ends the run
    wb(1'h1, bes_pkg::ADR_CTRL, 32'h0);
    gw(2'h0, bes_pkg::GF_ACTION, 32'h40001);
    wb(1'h1, bes_pkg::ADR_CTRL, 32'h1);
    tc(32'h100, d, x, 3'h3);
    rd(bes_pkg::ADR_CTRL, 32'h0);
    repeat (4) @(posedge clk_i);
    chk(rq.size() == 0 && tq.size() == 0 && aq.size() == 0, "results missing");
    final_report();
  end
endmodule : tb_bus_event_sequencer
`default_nettype wire
